// ===== rtl/dea_controller.sv
// data memory access controller: 256-byte array behind AXI4-Lite registers
// assumes one core clock; abort events arrive synchronous as levels
//
// Contract
// - 256 byte locations addressed by location register
// - data register carries bytes both ways
// - array reached only through its registers
// - byte write erases then programs
// - internal timer ends each write
// - protected array reads zero to programmer
// - control upper nibble ignored, reads zero
// - strobes set by software, cleared by hardware
// - writes happen only with store permit
// - power-on clears store permit
// - reset events during write set abort flag
// - aborting reset clears data and location
// - write end sets done flag, software clears
// - unlock port stores nothing, reads zero
// - fetched byte lands next cycle
// - data register holds fetched byte
// - 55h, AAh, store strobe unlock a write
// - store strobe refused without permit
// - no writes while power-up timer runs
// - hardware never clears store permit
`timescale 1ns/1ps
`default_nettype none
module dea_controller #(
	parameter int POWERUP_CYCLES = dea_pkg::POWERUP_CYC,  // power-up timer length
	parameter int WRITE_CYCLES   = dea_pkg::WRITE_CYC,    // write cycle length
	parameter int UNLOCK_CYCLES  = dea_pkg::UNLOCK_CYC    // unlock step window
) (
	input  wire logic                      clock_i,          // core clock
	input  wire logic                      reset_n_i,        // power-on reset, active low
	input  wire logic                      ce_i,             // clock enable
	// reset events that cut a write short
	input  wire logic                      ext_reset_evt_i,  // external_reset_pin event
	input  wire logic                      wdt_reset_evt_i,  // watchdog_timer reset
	input  wire logic                      bod_evt_i,        // brownout_detect event
	// external programmer read port
	input  wire logic                      code_protect_i,   // data protection active
	input  wire logic [7:0]                prog_addr_i,      // programmer read address
	output logic      [7:0]                prog_data_o,      // programmer read data
	output logic                           store_busy_o,     // write cycle under way
	// AXI4-Lite slave
	input  wire logic [dea_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [dea_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	// refuse settings the counters cannot hold
	if (POWERUP_CYCLES < 0 || UNLOCK_CYCLES < 1 || UNLOCK_CYCLES > 255) begin : g_bad_param
		$error("controller parameter out of range");
	end

	typedef struct packed {
		logic [dea_pkg::DEPTH-1:0][7:0] mem;        // the non-volatile array
		logic [7:0]                     data;       // nvm_data_reg
		logic [7:0]                     loc;        // nvm_location_reg
		logic                           fetch;      // fetch_strobe
		logic                           store;      // store_strobe
		logic                           permit;     // store_permit
		logic                           abort;      // store_abort_flag
		logic                           done;       // store_done_flag
		logic [7:0]                     w_loc;      // location of the write under way
		logic [7:0]                     w_data;     // byte of the write under way
		dea_pkg::dea_unlock_t           unl;        // unlock sequence progress
		logic [7:0]                     unl_cnt;    // cycles since last unlock step
		logic [31:0]                    pwrt;       // power-up cycles left
		logic                           aw_got;     // write address held
		logic [dea_pkg::ADDR_W-1:0]     awaddr;     // held write address
		logic                           w_got;      // write data held
		logic [31:0]                    wdata;      // held write data
		logic                           wlane0;     // low byte lane enabled
		logic                           awready;
		logic                           wready;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           arready;
		logic                           rvalid;
		logic [31:0]                    rdata;
		logic [1:0]                     rresp;
		logic [7:0]                     prog_data;  // programmer read data
	} dea_state_t;

	dea_state_t s_r;    // registered state
	dea_state_t s_nxt;  // next state

	logic timer_start;  // begin the write timer this cycle
	logic timer_done;   // write timer expired
	logic abort_evt;    // any reset event that cuts a write short

	assign abort_evt = ext_reset_evt_i | wdt_reset_evt_i | bod_evt_i;

	// one timer per write; only this block starts it
	dea_write_timer #(
		.CYCLES (WRITE_CYCLES)
	) u_timer (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.start_i   (timer_start),
		.abort_i   (abort_evt),
		.done_o    (timer_done)
	);

	// all register, bus and array behaviour
	always_comb begin
		logic                   wr_go;   // a held write is carried out now
		logic [7:0]             wbyte;   // low byte of the held write
		logic                   hit;     // held write address is mapped
		logic [dea_pkg::ADDR_W-1:0] ra;  // read address
		wr_go = 1'b0;
		wbyte = 8'h00;
		hit = 1'b0;
		ra = s_axi_araddr;
		s_nxt = s_r;
		timer_start = 1'b0;

		// power-up timer runs down once after power-on
		if (s_r.pwrt != 32'h0) begin
			s_nxt.pwrt = s_r.pwrt - 32'h1;
		end

		// a fetch strobe loads the addressed byte one cycle later
		if (s_r.fetch) begin
			s_nxt.data = s_r.mem[s_r.loc];
			s_nxt.fetch = 1'b0;
		end

		// unlock window: a late step drops the sequence
		if (s_r.unl != dea_pkg::UNL_IDLE) begin
			if (s_r.unl_cnt >= 8'(UNLOCK_CYCLES)) begin
				s_nxt.unl = dea_pkg::UNL_IDLE;
			end else begin
				s_nxt.unl_cnt = s_r.unl_cnt + 8'h1;
			end
		end

		// write channel capture, address and data in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wlane0 = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// carry out a held write once both halves are in
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			wr_go = s_r.wlane0;
			wbyte = s_r.wdata[7:0];
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			hit = (s_r.awaddr == dea_pkg::ADDR_DATA) || (s_r.awaddr == dea_pkg::ADDR_LOCATION)
				|| (s_r.awaddr == dea_pkg::ADDR_CONTROL) || (s_r.awaddr == dea_pkg::ADDR_UNLOCK)
				|| (s_r.awaddr == dea_pkg::ADDR_PERIPH);
			s_nxt.bresp = hit ? dea_pkg::RESP_OKAY : dea_pkg::RESP_SLVERR;
		end

		// register writes; a write with lane 0 off changes nothing
		if (wr_go) begin
			// any write other than the next unlock step breaks the sequence
			s_nxt.unl = dea_pkg::UNL_IDLE;
			s_nxt.unl_cnt = 8'h00;
			if (s_r.awaddr == dea_pkg::ADDR_DATA) begin
				s_nxt.data = wbyte;
			end else if (s_r.awaddr == dea_pkg::ADDR_LOCATION) begin
				s_nxt.loc = wbyte;
			end else if (s_r.awaddr == dea_pkg::ADDR_CONTROL) begin
				// bits 7..4 are simply not looked at
				s_nxt.permit = wbyte[dea_pkg::BIT_PERMIT];
				s_nxt.abort = wbyte[dea_pkg::BIT_ABORT];
				if (wbyte[dea_pkg::BIT_FETCH]) begin
					s_nxt.fetch = 1'b1;
				end
				// store strobe sets only after the unlock keys, with permit,
				// after the power-up timer, and not over a write in flight
				if (wbyte[dea_pkg::BIT_STORE] && !s_r.store
					&& s_r.unl == dea_pkg::UNL_ARMED
					&& wbyte[dea_pkg::BIT_PERMIT]
					&& s_r.pwrt == 32'h0) begin
					s_nxt.store = 1'b1;
					// operands are latched so the write is self-contained
					s_nxt.w_loc = s_r.loc;
					s_nxt.w_data = s_r.data;
					s_nxt.mem[s_r.loc] = dea_pkg::ERASED_BYTE;
					timer_start = 1'b1;
				end
			end else if (s_r.awaddr == dea_pkg::ADDR_UNLOCK) begin
				// key port has no storage; it only advances the sequence
				if (wbyte == dea_pkg::KEY_FIRST) begin
					s_nxt.unl = dea_pkg::UNL_GOT_FIRST;
				end else if (wbyte == dea_pkg::KEY_SECOND
					&& s_r.unl == dea_pkg::UNL_GOT_FIRST) begin
					s_nxt.unl = dea_pkg::UNL_ARMED;
				end
			end else if (s_r.awaddr == dea_pkg::ADDR_PERIPH) begin
				s_nxt.done = wbyte[dea_pkg::BIT_DONE];
			end
		end

		// timer expiry programs the byte; set wins over a same-cycle clear
		if (timer_done && s_r.store) begin
			s_nxt.mem[s_r.w_loc] = s_r.w_data;
			s_nxt.store = 1'b0;
			s_nxt.done = 1'b1;
			s_nxt.abort = 1'b0;
		end

		// reset events: data, location, strobes and unlock return to reset state; permit and done are kept
		if (abort_evt) begin
			if (s_r.store) begin
				s_nxt.abort = 1'b1;
			end
			s_nxt.store = 1'b0;
			s_nxt.fetch = 1'b0;
			s_nxt.data = dea_pkg::RST_BYTE;
			s_nxt.loc = dea_pkg::RST_BYTE;
			s_nxt.unl = dea_pkg::UNL_IDLE;
			timer_start = 1'b0;
		end

		// read channel; the array itself has no address here
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = dea_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (ra == dea_pkg::ADDR_DATA) begin
				s_nxt.rdata[7:0] = s_r.data;
			end else if (ra == dea_pkg::ADDR_LOCATION) begin
				s_nxt.rdata[7:0] = s_r.loc;
			end else if (ra == dea_pkg::ADDR_CONTROL) begin
				s_nxt.rdata[dea_pkg::BIT_FETCH] = s_r.fetch;
				s_nxt.rdata[dea_pkg::BIT_STORE] = s_r.store;
				s_nxt.rdata[dea_pkg::BIT_PERMIT] = s_r.permit;
				s_nxt.rdata[dea_pkg::BIT_ABORT] = s_r.abort;
			end else if (ra == dea_pkg::ADDR_UNLOCK) begin
				s_nxt.rdata = 32'h0000_0000;
			end else if (ra == dea_pkg::ADDR_PERIPH) begin
				s_nxt.rdata[dea_pkg::BIT_DONE] = s_r.done;
			end else begin
				s_nxt.rresp = dea_pkg::RESP_SLVERR;
			end
		end

		// readies follow the held state so at most one of each is in flight
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;

		// programmer sees zeros while data protection is on
		s_nxt.prog_data = code_protect_i ? 8'h00 : s_r.mem[prog_addr_i];
	end

	// state register; power-on clears everything including permit, but loads the power-up timer
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
			s_r.pwrt <= 32'(POWERUP_CYCLES);
			s_r.unl <= dea_pkg::UNL_IDLE;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// every output straight from the state register
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign prog_data_o = s_r.prog_data;
	assign store_busy_o = s_r.store;
endmodule // dea_controller
`default_nettype wire

// ===== rtl/dea_pkg.sv
// constants, offsets and types of the data memory access controller
// assumes a 100 MHz core clock and a 32-bit register bus
`default_nettype none
package dea_pkg;
	// printed register indices; byte address is four times the index
	localparam logic [7:0]  IDX_DATA      = 8'h9A;  // nvm_data_reg
	localparam logic [7:0]  IDX_LOCATION  = 8'h9B;  // nvm_location_reg
	localparam logic [7:0]  IDX_CONTROL   = 8'h9C;  // nvm_control_reg
	localparam logic [7:0]  IDX_UNLOCK    = 8'h9D;  // unlock_key_port, no storage
	localparam logic [7:0]  IDX_PERIPH    = 8'h0C;  // peripheral_flag_reg
	localparam int          ADDR_W        = 12;     // bus address width
	localparam logic [11:0] ADDR_DATA     = {2'h0, IDX_DATA, 2'h0};
	localparam logic [11:0] ADDR_LOCATION = {2'h0, IDX_LOCATION, 2'h0};
	localparam logic [11:0] ADDR_CONTROL  = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_UNLOCK   = {2'h0, IDX_UNLOCK, 2'h0};
	localparam logic [11:0] ADDR_PERIPH   = {2'h0, IDX_PERIPH, 2'h0};
	// control register field positions
	localparam int          BIT_FETCH     = 0;      // fetch_strobe
	localparam int          BIT_STORE     = 1;      // store_strobe
	localparam int          BIT_PERMIT    = 2;      // store_permit
	localparam int          BIT_ABORT     = 3;      // store_abort_flag
	localparam int          BIT_DONE      = 7;      // store_done_flag in peripheral flags
	// reset values and data constants
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;  // cell value after the erase phase
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'hAA;
	localparam int          DEPTH         = 256;    // locations 0 .. 255
	// answers of the bus
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// timing
	localparam int          CLK_MHZ       = 100;
	localparam int          POWERUP_MS    = 64;     // power-up timer
	localparam int          POWERUP_CYC   = POWERUP_MS * 1000 * CLK_MHZ;
	localparam int          WRITE_US      = 5000;   // internal write timer period
	localparam int          WRITE_CYC     = WRITE_US * CLK_MHZ;
	localparam int          UNLOCK_CYC    = 16;     // most cycles between unlock steps
	// unlock sequence progress
	typedef enum logic [1:0] {
		UNL_IDLE,
		UNL_GOT_FIRST,
		UNL_ARMED
	} dea_unlock_t;
endpackage
`default_nettype wire

// ===== rtl/dea_write_timer.sv
// internal write timer: times one program cycle of the array
// assumes start_i is a one-cycle pulse and ce_i gates every edge
`timescale 1ns/1ps
`default_nettype none
module dea_write_timer #(
	parameter int CYCLES = dea_pkg::WRITE_CYC  // length of one write cycle
) (
	input  wire logic clock_i,    // core clock
	input  wire logic reset_n_i,  // asynchronous reset, active low
	input  wire logic ce_i,       // clock enable
	input  wire logic start_i,    // begin timing a write
	input  wire logic abort_i,    // stop timing, no completion
	output logic      done_o      // one-cycle completion pulse
);
	// a zero-length cycle cannot be timed
	if (CYCLES < 1) begin : g_bad_cycles
		$error("write timer needs at least one cycle");
	end

	typedef struct packed {
		logic        busy;  // a write cycle is being timed
		logic [31:0] cnt;   // cycles left
		logic        done;  // completion pulse
	} dea_tmr_t;

	dea_tmr_t s_r;    // registered state
	dea_tmr_t s_nxt;  // next state

	// count down; abort wins so a cut-short write never reports completion
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (abort_i) begin
			s_nxt.busy = 1'b0;
		end else if (start_i) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt = 32'(CYCLES - 1);
		end else if (s_r.busy) begin
			if (s_r.cnt == 32'h0) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt - 32'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign done_o = s_r.done;
endmodule // dea_write_timer
`default_nettype wire

// ===== verification/dea_core_model.sv
// processor core model: drives the register bus as an AXI4-Lite master
// assumes one write and one read at most under way, tasks called in turn
`timescale 1ns/1ps
`default_nettype none
module dea_core_model (
	input  wire logic                       clock_i,
	output var  logic [dea_pkg::ADDR_W-1:0] s_axi_awaddr,
	output var  logic                       s_axi_awvalid,
	input  wire logic                       s_axi_awready,
	output var  logic [31:0]                s_axi_wdata,
	output var  logic [3:0]                 s_axi_wstrb,
	output var  logic                       s_axi_wvalid,
	input  wire logic                       s_axi_wready,
	input  wire logic [1:0]                 s_axi_bresp,
	input  wire logic                       s_axi_bvalid,
	output var  logic                       s_axi_bready,
	output var  logic [dea_pkg::ADDR_W-1:0] s_axi_araddr,
	output var  logic                       s_axi_arvalid,
	input  wire logic                       s_axi_arready,
	input  wire logic [31:0]                s_axi_rdata,
	input  wire logic [1:0]                 s_axi_rresp,
	input  wire logic                       s_axi_rvalid,
	output var  logic                       s_axi_rready
);
	int stall = 0;  // edges the core lets pass before taking read data
	logic [3:0] strb = 4'hF;  // byte lanes offered with the next write
	// quiet bus at time zero; all four byte lanes enabled
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// one write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		fork
			begin
				do @(posedge clock_i); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge clock_i); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// one read; a stall holds rready low so the answer must stand
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clock_i); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (stall) @(posedge clock_i);
		s_axi_rready <= 1'b1;
		do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // dea_core_model
`default_nettype wire

// ===== verification/dea_properties.sv
// checker for the data memory access controller, bound to its ports
// assumes ce_i stays high while answers are timed; counters follow ce_i
`timescale 1ns/1ps
`default_nettype none
module dea_properties #(
	parameter int POWERUP_CYCLES = 20,  // power-up timer length
	parameter int WRITE_CYCLES   = 10   // write cycle length
) (
	input wire logic                       clock_i,
	input wire logic                       reset_n_i,
	input wire logic                       ce_i,
	input wire logic                       ext_reset_evt_i,
	input wire logic                       wdt_reset_evt_i,
	input wire logic                       bod_evt_i,
	input wire logic                       code_protect_i,
	input wire logic [7:0]                 prog_data_o,
	input wire logic                       store_busy_o,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic [dea_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	wire logic   evt = ext_reset_evt_i | wdt_reset_evt_i | bod_evt_i;  // any aborting event
	logic [31:0] pup_r;   // enabled edges since release, saturating
	logic [7:0]  busy_r;  // samples in a row with a write under way
	logic        hit_r;   // an aborting event met the running write
	// counters tick on enabled edges only, like the design's own timers
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pup_r  <= 32'h0;
			busy_r <= 8'h0;
			hit_r  <= 1'b0;
		end else if (ce_i) begin
			if (pup_r < POWERUP_CYCLES) begin
				pup_r <= pup_r + 32'h1;
			end
			busy_r <= store_busy_o ? busy_r + 8'h1 : 8'h0;
			hit_r  <= store_busy_o & (hit_r | evt);
		end
	end
	a_prog_protect: assert property (ce_i && code_protect_i |=> prog_data_o == 8'h00)
		else $error("programmer port leaks data");
	a_write_length: assert property ($fell(store_busy_o) && !hit_r |-> busy_r == WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	a_abort_stops: assert property (ce_i && store_busy_o && evt |-> ##[1:2] !store_busy_o)
		else $error("write not cut short");
	a_powerup_block: assert property (pup_r < POWERUP_CYCLES |-> !store_busy_o)
		else $error("write during power-up");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
		|=> s_axi_rresp == dea_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_key_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == dea_pkg::ADDR_UNLOCK
		|=> s_axi_rdata == 32'h0)
		else $error("unlock port reads nonzero");
	a_ctl_upper: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == dea_pkg::ADDR_CONTROL
		|=> s_axi_rdata[31:4] == 28'h0)
		else $error("control upper bits nonzero");
	c_write_run: cover property ($rose(store_busy_o));
	c_write_cut: cover property ($fell(store_busy_o) && hit_r);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == dea_pkg::RESP_SLVERR);
endmodule // dea_properties
bind dea_controller dea_properties #(
	.POWERUP_CYCLES(POWERUP_CYCLES),
	.WRITE_CYCLES(WRITE_CYCLES)
) dea_properties_inst (.*);
`default_nettype wire

// ===== verification/tb_dea_controller.sv
// bench for the data memory access controller: register tests over the bus
// assumes the core model and the bound checker; short timers set below
`timescale 1ns/1ps
`default_nettype none
module tb_dea_controller;
	localparam logic [11:0] DAT = dea_pkg::ADDR_DATA;
	localparam logic [11:0] LOC = dea_pkg::ADDR_LOCATION;
	localparam logic [11:0] CTL = dea_pkg::ADDR_CONTROL;
	localparam logic [11:0] KEY = dea_pkg::ADDR_UNLOCK;
	localparam logic [11:0] PIR = dea_pkg::ADDR_PERIPH;
	localparam logic [1:0]  ERR = dea_pkg::RESP_SLVERR;
	logic             clock_i = 1'b0;
	logic             reset_n_i = 1'b0;
	logic             ce_i = 1'b1;
	logic             ext_reset_evt_i = 1'b0, wdt_reset_evt_i = 1'b0, bod_evt_i = 1'b0;
	logic             code_protect_i = 1'b0;
	logic [7:0]       prog_addr_i = 8'h05;
	wire logic [7:0]  prog_data_o;
	wire logic        store_busy_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire logic        s_axi_rvalid, s_axi_rready;
	wire logic [11:0] s_axi_awaddr, s_axi_araddr;
	wire logic [31:0] s_axi_wdata, s_axi_rdata;
	wire logic [3:0]  s_axi_wstrb;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	int               errors = 0;
	int               checked = 0;
	dea_controller #(.POWERUP_CYCLES(40), .WRITE_CYCLES(10)) dea_controller_inst (.*);
	dea_core_model core_inst (.*);
	always #5 clock_i = ~clock_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic [1:0] r;
		core_inst.wr(a, {24'h0, d}, r);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
		logic [31:0] d;
		logic [1:0]  r;
		core_inst.rd(a, d, r);
		chk(d, {24'h0, e});
		chk({30'h0, r}, {30'h0, er});
	endtask
	// busy is the store strobe register itself, so look one edge on
	task automatic busy(input logic e);
		@(posedge clock_i);
		#1;
		chk({31'h0, store_busy_o}, {31'h0, e});
	endtask
	task automatic unlock(input logic [7:0] c);
		wr(KEY, dea_pkg::KEY_FIRST);
		wr(KEY, dea_pkg::KEY_SECOND);
		wr(CTL, c);
	endtask
	task automatic store(input logic [7:0] l, input logic [7:0] d);
		wr(LOC, l);
		wr(DAT, d);
		unlock(8'h06);
		busy(1'b1);
	endtask
	// bounded wait for the write cycle to finish
	task automatic settle;
		for (int k = 0; k < 40 && store_busy_o !== 1'b0; k++) @(posedge clock_i);
		#1;
		chk({31'h0, store_busy_o}, 32'h0);
	endtask
	task automatic conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		conclude;
	end
	initial begin
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		rd(CTL, 8'h00);
		unlock(8'h06);
		busy(1'b0);
		repeat (40) @(posedge clock_i);
		rd(DAT, 8'h00);
		rd(LOC, 8'h00);
		rd(KEY, 8'h00);
		rd(PIR, 8'h00);
		rd(12'h000, 8'h00, ERR);
		wr(12'h000, 8'h5A, ERR);
		$display("test reset done");
		wr(CTL, 8'h00);
		unlock(8'h02);
		busy(1'b0);
		rd(CTL, 8'h00);
		wr(KEY, dea_pkg::KEY_SECOND);
		wr(KEY, dea_pkg::KEY_FIRST);
		wr(CTL, 8'h06);
		busy(1'b0);
		wr(KEY, dea_pkg::KEY_FIRST);
		wr(LOC, 8'h05);
		wr(KEY, dea_pkg::KEY_SECOND);
		wr(CTL, 8'h06);
		busy(1'b0);
		$display("test refusals done");
		store(8'h05, 8'h3C);
		busy(1'b1);
		chk({24'h0, prog_data_o}, {24'h0, dea_pkg::ERASED_BYTE});
		rd(CTL, 8'h06);
		settle;
		rd(CTL, 8'h04);
		rd(PIR, 8'h80);
		chk({24'h0, prog_data_o}, 32'h3C);
		wr(PIR, 8'h00);
		rd(PIR, 8'h00);
		$display("test write done");
		store(8'hFF, 8'hA5);
		settle;
		wr(DAT, 8'h00);
		wr(LOC, 8'h05);
		wr(CTL, 8'h05);
		rd(DAT, 8'h3C);
		rd(CTL, 8'h04);
		wr(LOC, 8'hFF);
		core_inst.stall = 2;
		rd(DAT, 8'h3C);
		core_inst.stall = 0;
		wr(CTL, 8'h05);
		rd(DAT, 8'hA5);
		$display("test fetch done");
		@(posedge clock_i) code_protect_i <= 1'b1;
		prog_addr_i <= 8'hFF;
		repeat (2) @(posedge clock_i);
		#1;
		chk({24'h0, prog_data_o}, 32'h0);
		wr(CTL, 8'h05);
		rd(DAT, 8'hA5);
		// a write with the low lane off must leave the data register alone
		core_inst.strb = 4'hE;
		wr(DAT, 8'h11);
		core_inst.strb = 4'hF;
		rd(DAT, 8'hA5);
		@(posedge clock_i) code_protect_i <= 1'b0;
		$display("test protect done");
		for (int i = 0; i < 3; i++) begin
			store(8'h10, 8'h77);
			repeat (3) @(posedge clock_i);
			{bod_evt_i, wdt_reset_evt_i, ext_reset_evt_i} <= 3'b001 << i;
			@(posedge clock_i) {bod_evt_i, wdt_reset_evt_i, ext_reset_evt_i} <= 3'b000;
			settle;
			rd(CTL, 8'h0C);
			rd(DAT, 8'h00);
			rd(LOC, 8'h00);
		end
		wr(CTL, 8'hF4);
		rd(CTL, 8'h04);
		$display("test abort done");
		conclude;
	end
endmodule // tb_dea_controller
`default_nettype wire
